// [hw/mrl_exec.sv]
`timescale 1ns/100ps


module mrl_exec
    import mrl_pkg::*;
#(
    parameter int PC_W = 11
)
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                reset,
    // Instruction issue from fetch
    input  wire logic                instr_valid,
    input  wire logic [WORD_W-1:0]   instr_word,
    // Hardware stack
    input  wire logic [PC_W-1:0]     stack_top_entry,
    output logic                     stack_pop,
    // Program counter load
    output logic                     pc_load,
    output logic [PC_W-1:0]          pc_value,
    // Fetch control
    output logic                     fetch_flush,
    // File register write port
    output logic                     file_we,
    output logic [FSEL_W-1:0]        file_addr,
    output logic [DATA_W-1:0]        file_wdata,
    // Architectural state held here
    output logic [DATA_W-1:0]        accumulator,
    output logic [DATA_W-1:0]        prescale_cfg
);

    // ********************************************************************
    // Decode.
    // ********************************************************************

    logic              is_store;
    logic              is_cfg;
    logic              is_idle;
    logic              is_ret;
    logic [FSEL_W-1:0] file_sel;
    logic [DATA_W-1:0] literal;
    mrl_state_e        state;
    mrl_state_e        next_state;
    logic              issue;

    mrl_decode u_decode
    (
        .word     (instr_word),
        .is_store (is_store),
        .is_cfg   (is_cfg),
        .is_idle  (is_idle),
        .is_ret   (is_ret),
        .file_sel (file_sel),
        .literal  (literal)
    );

    // A word counts only in the issue phase; in the discard phase the
    // word already fetched after a return belongs to the old flow.
    assign issue = instr_valid && (state == MRL_ISSUE);

    // ********************************************************************
    // Phase sequencing.
    // ********************************************************************

    always_comb
    begin
        case (state)
            MRL_ISSUE:
            begin
                if (issue && is_ret)
                    next_state = MRL_DISCARD;
                else
                    next_state = MRL_ISSUE;
            end
            MRL_DISCARD:
            begin
                next_state = MRL_ISSUE;
            end
            default:
            begin
                next_state = MRL_ISSUE;
            end
        endcase
    end

    // The phase register; reset returns to normal issue.
    always_ff @(posedge mclk)
    begin
        if (reset)
            state <= MRL_ISSUE;
        else
            state <= next_state;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            fetch_flush <= 1'b0;
        else
            fetch_flush <= (next_state == MRL_DISCARD);
    end

    // ********************************************************************
    // Accumulator.
    // ********************************************************************

    // Only the return word writes the accumulator here. No status flag is
    // touched by anything in this block, so none leaves it.
    // literal load
    always_ff @(posedge mclk)
    begin
        if (reset)
            accumulator <= ACC_RST;
        else if (issue && is_ret)
            accumulator <= literal;
    end

    // ********************************************************************
    // File register write.
    // ********************************************************************

    // The write is a one-cycle strobe with address and data registered
    // beside it, so the file array sees a clean, aligned request.
    // store to file
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            file_we    <= 1'b0;
            file_addr  <= '0;
            file_wdata <= '0;
        end
        else
        begin
            file_we <= issue && is_store;
            if (issue && is_store)
            begin
                file_addr  <= file_sel;
                file_wdata <= accumulator;
            end
        end
    end

    // ********************************************************************
    // Prescaler configuration and idle word.
    // ********************************************************************

    // The idle word needs no logic: it matches nothing that writes state.
    // config load
    always_ff @(posedge mclk)
    begin
        if (reset)
            prescale_cfg <= CFG_RST;
        else if (issue && is_cfg)
            prescale_cfg <= accumulator;
    end

    // ********************************************************************
    // Return address and stack pop.
    // ********************************************************************

    // The stack top is captured with the pop so the counter sees the value
    // from before the stack moves.
    // pop into counter
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pc_load   <= 1'b0;
            stack_pop <= 1'b0;
            pc_value  <= '0;
        end
        else
        begin
            pc_load   <= issue && is_ret;
            stack_pop <= issue && is_ret;
            if (issue && is_ret)
                pc_value <= stack_top_entry;
        end
    end

    // ********************************************************************
    // Assertions.
    // ********************************************************************

    property p_store;
        @(posedge mclk) disable iff (reset)
        (issue && is_store) |=> file_we && file_addr == $past(file_sel)
            && file_wdata == $past(accumulator);
    endproperty
    a_store: assert property (p_store)
        else $error("store word did not write the file register");

    property p_literal;
        @(posedge mclk) disable iff (reset)
        (issue && is_ret) |=> accumulator == $past(literal);
    endproperty
    a_literal: assert property (p_literal)
        else $error("return word did not load the literal");

    property p_return_pc;
        @(posedge mclk) disable iff (reset)
        (issue && is_ret) |=> pc_load && stack_pop
            && pc_value == $past(stack_top_entry);
    endproperty
    a_return_pc: assert property (p_return_pc)
        else $error("return word did not pop the stack into the counter");

    property p_two_cycle;
        @(posedge mclk) disable iff (reset)
        (issue && is_ret) |=> state == MRL_DISCARD && fetch_flush
            ##1 state == MRL_ISSUE && !fetch_flush;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("return did not take exactly two cycles");

    property p_discard;
        @(posedge mclk) disable iff (reset)
        (state == MRL_DISCARD) |=> !file_we && !pc_load
            && $stable(accumulator) && $stable(prescale_cfg);
    endproperty
    a_discard: assert property (p_discard)
        else $error("discarded word changed state");

    property p_cfg;
        @(posedge mclk) disable iff (reset)
        (issue && is_cfg) |=> prescale_cfg == $past(accumulator)
            && $stable(accumulator) && !file_we;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config word did not load the prescaler config");

    property p_idle;
        @(posedge mclk) disable iff (reset)
        (issue && is_idle) |=> !file_we && !pc_load && !fetch_flush
            && $stable(accumulator) && $stable(prescale_cfg);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle word changed state");

endmodule : mrl_exec

// [hw/mrl_pkg.sv]
package mrl_pkg;

    // ********************************************************************
    // Widths of the core's data paths.
    // ********************************************************************
    localparam int WORD_W = 12;
    localparam int DATA_W = 8;
    localparam int FSEL_W = 5;

    // ********************************************************************
    // Instruction encodings and the masks that pick out their fixed bits.
    // ********************************************************************
    localparam logic [11:0] STORE_MASK = 12'hfe0;
    localparam logic [11:0] STORE_CODE = 12'h020;
    localparam logic [11:0] CFG_CODE   = 12'h002;
    localparam logic [11:0] IDLE_CODE  = 12'h000;
    localparam logic [11:0] RET_MASK   = 12'hf00;
    localparam logic [11:0] RET_CODE   = 12'h800;

    // ********************************************************************
    // Field positions inside the instruction word.
    // ********************************************************************
    localparam int FSEL_LSB = 0;
    localparam int LIT_LSB  = 0;

    // ********************************************************************
    // Reset values of the state held by this block.
    // ********************************************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;

    // ********************************************************************
    // Cycle counts of the instructions handled here.
    // ********************************************************************
    localparam int RET_CYCLES  = 2;
    localparam int ONE_CYCLE   = 1;

    // Execution phase: normal issue, or the discarded second cycle.
    typedef enum logic [0:0]
    {
        MRL_ISSUE   = 1'b0,
        MRL_DISCARD = 1'b1
    } mrl_state_e;

endpackage : mrl_pkg

// [hw/mrl_decode.sv]
`timescale 1ns/100ps

module mrl_decode
    import mrl_pkg::*;
(
    // Instruction word from fetch
    input  wire logic [WORD_W-1:0] word,
    // Decoded kind of the word
    output logic                   is_store,
    output logic                   is_cfg,
    output logic                   is_idle,
    output logic                   is_ret,
    // Operand fields
    output logic [FSEL_W-1:0]      file_sel,
    output logic [DATA_W-1:0]      literal
);

    // ********************************************************************
    // Pattern matching of the four words handled by this block.
    // ********************************************************************

    // Each pattern is exclusive, so at most one kind is ever set.
    always_comb
    begin
        is_store = (word & STORE_MASK) == STORE_CODE;
        is_cfg   = word == CFG_CODE;
        is_idle  = word == IDLE_CODE;
        is_ret   = (word & RET_MASK) == RET_CODE;
    end

    // Operand fields are extracted unconditionally; users gate them.
    assign file_sel = word[FSEL_LSB +: FSEL_W];
    assign literal  = word[LIT_LSB +: DATA_W];

endmodule : mrl_decode

// [bench/tb_top.sv]
`timescale 1ns/100ps

module tb_top
    import mrl_pkg::*;
;
    // ****************************************************************
    // Signals and table of ordinary cases.
    // ****************************************************************
    localparam int PC_W = 11;

    typedef struct {
        logic [11:0] word;
        logic [10:0] top;
        logic [7:0]  acc;
        logic [7:0]  cfg;
        logic        we;
        logic [4:0]  addr;
        logic [7:0]  wdata;
        logic        ret;
    } mrl_row_s;

    logic              mclk;
    logic              reset;
    logic              instr_valid;
    logic [WORD_W-1:0] instr_word;
    logic [PC_W-1:0]   stack_top_entry;
    logic [PC_W-1:0]   pc_value;
    logic              stack_pop;
    logic              pc_load;
    logic              fetch_flush;
    logic              file_we;
    logic [FSEL_W-1:0] file_addr;
    logic [DATA_W-1:0] file_wdata;
    logic [DATA_W-1:0] accumulator;
    logic [DATA_W-1:0] prescale_cfg;
    int                miscompares;
    int                n_compared;

    // Each row leans on the state left by the rows above it.
    mrl_row_s rows [12] = '{
        '{12'h000, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'h8a5, 11'h123, 8'ha5, 8'hff, 1'h0, 5'h00, 8'h00, 1'h1},
        '{12'h002, 11'h000, 8'ha5, 8'ha5, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'h03f, 11'h000, 8'ha5, 8'ha5, 1'h1, 5'h1f, 8'ha5, 1'h0},
        '{12'h8ff, 11'h7ff, 8'hff, 8'ha5, 1'h0, 5'h00, 8'h00, 1'h1},
        '{12'h020, 11'h000, 8'hff, 8'ha5, 1'h1, 5'h00, 8'hff, 1'h0},
        '{12'h002, 11'h000, 8'hff, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'h800, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h1},
        '{12'h001, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'h040, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'h9ff, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0},
        '{12'hc5a, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00, 8'h00, 1'h0}
    };

    mrl_exec #(.PC_W(PC_W)) i_dut (
        .mclk            (mclk),
        .reset           (reset),
        .instr_valid     (instr_valid),
        .instr_word      (instr_word),
        .stack_top_entry (stack_top_entry),
        .stack_pop       (stack_pop),
        .pc_load         (pc_load),
        .pc_value        (pc_value),
        .fetch_flush     (fetch_flush),
        .file_we         (file_we),
        .file_addr       (file_addr),
        .file_wdata      (file_wdata),
        .accumulator     (accumulator),
        .prescale_cfg    (prescale_cfg)
    );

    // ****************************************************************
    // Clock, tasks and closing.
    // ****************************************************************
    initial
    begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    // Widened to 16 bits; case inequality keeps unknowns from matching.
    task check(input string name, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Inputs change on the edge and outputs are read 1 ns later.
    task drive(input logic v, input logic [11:0] w, input logic [10:0] t);
        @(posedge mclk);
        instr_valid     <= v;
        instr_word      <= w;
        stack_top_entry <= t;
        #1;
    endtask : drive

    task check_state(input mrl_row_s r);
        check("accumulator", accumulator, r.acc);
        check("prescale_cfg", prescale_cfg, r.cfg);
        check("file_we", file_we, r.we);
        if (r.we)
        begin
            check("file_addr", file_addr, r.addr);
            check("file_wdata", file_wdata, r.wdata);
        end
        check("pc_load", pc_load, r.ret);
        check("stack_pop", stack_pop, r.ret);
        check("fetch_flush", fetch_flush, r.ret);
        if (r.ret)
            check("pc_value", pc_value, r.top);
    endtask : check_state

    task summarize;
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // A hang is cut short well beyond the 41 or so cycles needed.
    initial
    begin
        repeat (2000) @(posedge mclk);
        miscompares++;
        summarize();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        miscompares = 0;
        n_compared  = 0;
        reset           = 1'h1;
        instr_valid     = 1'h0;
        instr_word      = 12'h000;
        stack_top_entry = 11'h000;
        repeat (8) @(posedge mclk);
        reset <= 1'h0;
        #1;
        check_state('{12'h000, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00,
                      8'h00, 1'h0});
        check("pc_value", pc_value, 16'h0000);
        $display("Test reset done");
        // table of all kinds of word
        foreach (rows[i])
        begin
            drive(1'h1, rows[i].word, rows[i].top);
            drive(1'h0, 12'h000, 11'h000);
            check_state(rows[i]);
        end
        $display("Test table done");
        drive(1'h1, 12'h83c, 11'h055);
        drive(1'h1, 12'h02a, 11'h000);
        check("fetch_flush", fetch_flush, 16'h0001);
        check("pc_value", pc_value, 16'h0055);
        drive(1'h1, 12'h025, 11'h000);
        check("file_we", file_we, 16'h0000);
        check("pc_load", pc_load, 16'h0000);
        check("fetch_flush", fetch_flush, 16'h0000);
        drive(1'h1, 12'h002, 11'h000);
        check("file_we", file_we, 16'h0001);
        check("file_addr", file_addr, 16'h0005);
        check("file_wdata", file_wdata, 16'h003c);
        drive(1'h0, 12'h000, 11'h000);
        check("file_we", file_we, 16'h0000);
        check("prescale_cfg", prescale_cfg, 16'h003c);
        $display("Test discard done");
        // A return met by reset in mid-run must not be taken.
        @(posedge mclk);
        reset       <= 1'h1;
        instr_valid <= 1'h1;
        instr_word  <= 12'h8aa;
        drive(1'h0, 12'h000, 11'h000);
        check_state('{12'h000, 11'h000, 8'h00, 8'hff, 1'h0, 5'h00,
                      8'h00, 1'h0});
        // word at first edge after release
        @(posedge mclk);
        reset           <= 1'h0;
        instr_valid     <= 1'h1;
        instr_word      <= 12'h8c3;
        stack_top_entry <= 11'h011;
        drive(1'h0, 12'h000, 11'h000);
        check_state('{12'h8c3, 11'h011, 8'hc3, 8'hff, 1'h0, 5'h00,
                      8'h00, 1'h1});
        $display("Test mid reset done");
        summarize();
    end

endmodule : tb_top
